/* File: verilog/ucfg_pkg.sv */
// Package with offsets, fields and reset values of the user config bank
package ucfg_pkg;
    localparam int          UCFG_AW           = 12;
    localparam int          UCFG_DW           = 32;
    localparam logic [11:0] FW_BASE           = 12'h014;
    localparam int          FW_COUNT          = 13;
    localparam logic [11:0] HW_BASE           = 12'h050;
    localparam int          HW_COUNT          = 12;
    localparam logic [11:0] CUST_BASE         = 12'h080;
    localparam int          CUST_COUNT        = 32;
    localparam int          ARRAY_WORDS       = 57;
    localparam int          ARRAY_IW          = 6;
    localparam logic [5:0]  HW_IDX0           = 6'h0d;
    localparam logic [5:0]  CUST_IDX0         = 6'h19;
    localparam logic [11:0] RST_SEL0_ADDR     = 12'h200;
    localparam logic [11:0] RST_SEL1_ADDR     = 12'h204;
    localparam logic [11:0] PORT_LOCK_ADDR    = 12'h208;
    localparam logic [11:0] PIN_ROLE_ADDR     = 12'h20c;
    localparam logic [11:0] DEBUG_FEAT_ADDR   = 12'h210;
    localparam logic [11:0] REG_LEVEL_ADDR    = 12'h304;
    localparam logic [31:0] ERASED_WORD       = 32'hffff_ffff;
    localparam logic [31:0] READ_ZERO         = 32'h0000_0000;
    localparam int          PIN_LSB           = 0;
    localparam int          PIN_W             = 5;
    localparam int          PORT_BIT          = 5;
    localparam int          CONNECT_BIT       = 31;
    localparam logic        CONNECTED         = 1'b0;
    localparam int          ROLE_BIT          = 0;
    localparam logic        ROLE_ANTENNA      = 1'b1;
    localparam int          TRACE_LSB         = 0;
    localparam int          BKPT_LSB          = 8;
    localparam logic [7:0]  FEATURE_ON        = 8'hff;
endpackage

/* File: verilog/ucfg_word_mem.sv */
// Word memory for the reserved word arrays, registered read data
`timescale 1ns/1ps
module ucfg_word_mem
    import ucfg_pkg::*;
#(
    parameter int DEPTH = ARRAY_WORDS,
    parameter int IW    = ARRAY_IW
) (
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic          wr_en,
    input  wire logic [IW-1:0] wr_idx,
    input  wire logic [31:0]   wr_data,
    input  wire logic [IW-1:0] rd_idx,
    output logic      [31:0]   rd_data
);
    logic [31:0] mem_reg [DEPTH] = '{default: ERASED_WORD};

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_word
            always_ff @(posedge clk) begin
                if (wr_en && (wr_idx == IW'(gi))) begin
                    mem_reg[gi] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= ERASED_WORD;
        end else begin
            rd_data <= (int'(rd_idx) < DEPTH) ? mem_reg[rd_idx] : ERASED_WORD;
        end
    end
endmodule

/* File: verilog/ucfg_regs.sv */
// User configuration register bank with decoded control outputs
//
// Function
// - Firmware, hardware, customer word arrays, 4-byte stride, erased ones.
// - Reset pin mapping valid only when both selection copies match.
// - Mismatched copies expose no external reset on any GPIO.
// - Selection word holds pin, port and active-low connect bit.
// - Pin role 0 runs dedicated pins as GPIO, normal protection.
// - Pin role 1 runs dedicated pins as antenna, antenna protection.
// - Trace field 0xFF enables instrumentation and embedded trace.
// - Breakpoint field 0xFF enables unit; disabled drops its writes.
// - Word at 0x304 selects first regulator stage output level.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module ucfg_regs
    import ucfg_pkg::*;
(
    input  wire logic         CLK,
    input  wire logic         ARST_N,
    input  wire logic [11:0]  ADDR,
    input  wire logic [31:0]  WDATA,
    input  wire logic         WR,
    input  wire logic         RD,
    input  wire logic         BKPT_WR,
    output logic      [31:0]  RDATA,
    output logic              CFG_READY,
    output logic              EXT_RESET_EN,
    output logic      [4:0]   EXT_RESET_PIN,
    output logic              EXT_RESET_PORT,
    output logic              PINS_ANTENNA,
    output logic              PINS_GPIO,
    output logic              TRACE_EN,
    output logic              BKPT_EN,
    output logic              BKPT_WR_ALLOW,
    output logic      [31:0]  PORT_LOCK,
    output logic      [31:0]  REG_LEVEL
);
    typedef enum logic [1:0] {ST_RESET, ST_SAMPLE, ST_RUN} ucfg_state_e;

    ucfg_state_e state_reg;
    ucfg_state_e state_next;
    // Non-volatile words, kept over reset
    logic [31:0] rst_sel0_reg = ERASED_WORD;
    logic [31:0] rst_sel1_reg = ERASED_WORD;
    logic [31:0] lock_reg     = ERASED_WORD;
    logic [31:0] role_reg     = ERASED_WORD;
    logic [31:0] dbg_reg      = ERASED_WORD;
    logic [31:0] level_reg    = ERASED_WORD;
    logic [31:0] mem_rdata;
    logic [31:0] rdata_next;
    logic        arr_rd_reg;
    logic [31:0] reg_rdata_reg;

    function automatic logic in_array(input logic [11:0] a,
                                      input logic [11:0] base,
                                      input int          cnt);
        logic [11:0] d;
        d = a - base;
        return (a >= base) && (a[1:0] == 2'b00) &&
               (int'(d[11:2]) < cnt);
    endfunction

    function automatic logic [5:0] arr_idx(input logic [11:0] a);
        logic [5:0] i;
        i = 6'h00;
        if (in_array(a, FW_BASE, FW_COUNT)) begin
            i = 6'(a[11:2] - FW_BASE[11:2]);
        end else if (in_array(a, HW_BASE, HW_COUNT)) begin
            i = 6'(a[11:2] - HW_BASE[11:2]) + HW_IDX0;
        end else begin
            i = 6'(a[11:2] - CUST_BASE[11:2]) + CUST_IDX0;
        end
        return i;
    endfunction

    wire logic hit_fw    = in_array(ADDR, FW_BASE, FW_COUNT);
    wire logic hit_hw    = in_array(ADDR, HW_BASE, HW_COUNT);
    wire logic hit_cust  = in_array(ADDR, CUST_BASE, CUST_COUNT);
    wire logic hit_array = hit_fw || hit_hw || hit_cust;
    wire logic [5:0] idx = arr_idx(ADDR);
    // Single word address decode
    wire logic       at_sel0  = (ADDR == RST_SEL0_ADDR);
    wire logic       at_sel1  = (ADDR == RST_SEL1_ADDR);
    wire logic       at_lock  = (ADDR == PORT_LOCK_ADDR);
    wire logic       at_role  = (ADDR == PIN_ROLE_ADDR);
    wire logic       at_dbg   = (ADDR == DEBUG_FEAT_ADDR);
    wire logic       at_level = (ADDR == REG_LEVEL_ADDR);
    // Write strobes per word
    wire logic       wr_sel0  = WR && at_sel0;
    wire logic       wr_sel1  = WR && at_sel1;
    wire logic       wr_lock  = WR && at_lock;
    wire logic       wr_role  = WR && at_role;
    wire logic       wr_dbg   = WR && at_dbg;
    wire logic       wr_level = WR && at_level;

    wire logic copies_match = (rst_sel0_reg == rst_sel1_reg);
    wire logic sel_connect = (rst_sel0_reg[CONNECT_BIT] == CONNECTED);
    wire logic ext_en_next = copies_match && sel_connect;
    wire logic trace_next = (dbg_reg[TRACE_LSB +: 8] == FEATURE_ON);
    wire logic bkpt_next = (dbg_reg[BKPT_LSB +: 8] == FEATURE_ON);
    wire logic antenna_next = (role_reg[ROLE_BIT] == ROLE_ANTENNA);
    wire logic sampling = (state_reg == ST_SAMPLE);

    ucfg_word_mem #(
        .DEPTH (ARRAY_WORDS),
        .IW    (ARRAY_IW)
    ) u_mem (
        .clk     (CLK),
        .arst_n  (ARST_N),
        .wr_en   (WR && hit_array),
        .wr_idx  (idx),
        .wr_data (WDATA),
        .rd_idx  (idx),
        .rd_data (mem_rdata)
    );

    always_comb begin
        case (state_reg)
            ST_RESET:  state_next = ST_SAMPLE;
            ST_SAMPLE: state_next = ST_RUN;
            ST_RUN:    state_next = ST_RUN;
            default:   state_next = ST_RESET;
        endcase
    end

    // Register read mux
    always_comb begin
        if (at_sel0) begin
            rdata_next = rst_sel0_reg;
        end else if (at_sel1) begin
            rdata_next = rst_sel1_reg;
        end else if (at_lock) begin
            rdata_next = lock_reg;
        end else if (at_role) begin
            rdata_next = role_reg;
        end else if (at_dbg) begin
            rdata_next = dbg_reg;
        end else if (at_level) begin
            rdata_next = level_reg;
        end else begin
            rdata_next = READ_ZERO;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (wr_sel0) begin
            rst_sel0_reg <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (wr_sel1) begin
            rst_sel1_reg <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (wr_lock) begin
            lock_reg <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (wr_role) begin
            role_reg <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (wr_dbg) begin
            dbg_reg <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (wr_level) begin
            level_reg <= WDATA;
        end
    end

    // Read answer path
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            arr_rd_reg <= 1'b0;
        end else begin
            arr_rd_reg <= RD && hit_array;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            reg_rdata_reg <= READ_ZERO;
        end else begin
            reg_rdata_reg <= RD ? rdata_next : READ_ZERO;
        end
    end

    assign RDATA = arr_rd_reg ? mem_rdata : reg_rdata_reg;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CFG_READY <= 1'b0;
        end else if (sampling) begin
            CFG_READY <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            EXT_RESET_EN   <= 1'b0;
            EXT_RESET_PIN  <= 5'h00;
            EXT_RESET_PORT <= 1'b0;
        end else if (sampling) begin
            EXT_RESET_EN   <= ext_en_next;
            EXT_RESET_PIN  <= ext_en_next ?
                              rst_sel0_reg[PIN_LSB +: PIN_W] : 5'h00;
            EXT_RESET_PORT <= ext_en_next & rst_sel0_reg[PORT_BIT];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PINS_GPIO <= 1'b0;
        end else if (sampling) begin
            PINS_GPIO <= !antenna_next;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PINS_ANTENNA <= 1'b0;
        end else if (sampling) begin
            PINS_ANTENNA <= antenna_next;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            TRACE_EN <= 1'b0;
        end else if (sampling) begin
            TRACE_EN <= trace_next;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            BKPT_EN <= 1'b0;
        end else if (sampling) begin
            BKPT_EN <= bkpt_next;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PORT_LOCK <= ERASED_WORD;
        end else if (sampling) begin
            PORT_LOCK <= lock_reg;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            BKPT_WR_ALLOW <= 1'b0;
        end else begin
            BKPT_WR_ALLOW <= BKPT_WR && BKPT_EN;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_LEVEL <= ERASED_WORD;
        end else begin
            REG_LEVEL <= level_reg;
        end
    end
endmodule

/* File: sim/ucfg_regs_chk.sv */
// Port checker for the user config bank
`timescale 1ns/1ps
module ucfg_chk
    import ucfg_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic [11:0] ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    input  wire logic        BKPT_WR,
    input  wire logic [31:0] RDATA,
    input  wire logic        CFG_READY,
    input  wire logic        EXT_RESET_EN,
    input  wire logic [4:0]  EXT_RESET_PIN,
    input  wire logic        EXT_RESET_PORT,
    input  wire logic        PINS_ANTENNA,
    input  wire logic        PINS_GPIO,
    input  wire logic        TRACE_EN,
    input  wire logic        BKPT_EN,
    input  wire logic        BKPT_WR_ALLOW,
    input  wire logic [31:0] REG_LEVEL
);
    logic [1:0] cnt_reg;
    logic       clean_reg = 1'b1;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // Edges since release
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_reg <= 2'h0;
        end else begin
            if (cnt_reg != 2'h3) cnt_reg <= cnt_reg + 2'h1;
        end
    end
    // Words stay erased until the first write of the run
    always_ff @(posedge CLK) begin
        if (WR) clean_reg <= 1'b0;
    end
    sequence cust_wr;
        WR && ADDR[11:7] == 5'h01 && ADDR[1:0] == 2'h0;
    endsequence
    sequence same_rd;
        RD && $stable(ADDR);
    endsequence
    ready_time_a: assert property (CFG_READY == (cnt_reg >= 2'h2))
        else $error("ready flag timing wrong");
    cfg_hold_a: assert property (CFG_READY && $past(CFG_READY) |->
        $stable(TRACE_EN) && $stable(BKPT_EN) && $stable(PINS_GPIO)
        && $stable(EXT_RESET_EN)) else $error("decoded setting moved");
    erased_dflt_a: assert property (cnt_reg == 2'h2 && clean_reg |->
        TRACE_EN && BKPT_EN && PINS_ANTENNA && !EXT_RESET_EN)
        else $error("erased defaults wrong");
    no_reset_map_a: assert property (!EXT_RESET_EN |->
        EXT_RESET_PIN == 5'h00 && !EXT_RESET_PORT) else $error("pin shown");
    pin_role_a: assert property (
        CFG_READY |-> PINS_GPIO != PINS_ANTENNA)
        else $error("pin role not exclusive");
    bkpt_gate_a: assert property (BKPT_WR && BKPT_EN && CFG_READY |=>
        BKPT_WR_ALLOW) else $error("breakpoint write lost");
    bkpt_idle_a: assert property (!(BKPT_WR && BKPT_EN) |=>
        !BKPT_WR_ALLOW) else $error("breakpoint write passed");
    unaligned_rd_a: assert property (RD && ADDR[1:0] != 2'h0 |=>
        RDATA == 32'h0000_0000) else $error("unaligned read not zero");
    wr_rd_a: assert property (cust_wr ##1 same_rd |=>
        RDATA == $past(WDATA, 2)) else $error("write then read differs");
    reg_level_a: assert property (WR && ADDR == REG_LEVEL_ADDR |->
        ##2 REG_LEVEL == $past(WDATA, 2)) else $error("level not copied");
endmodule
bind ucfg_regs ucfg_chk u_ucfg_chk (.*);

/* File: sim/ucfg_regs_tb.sv */
// Self-checking bench for the user config bank
`timescale 1ns/1ps
module ucfg_regs_tb import ucfg_pkg::*;;
    logic CLK = 1'b0, ARST_N = 1'b0, WR = 1'b0, RD = 1'b0, BKPT_WR = 1'b0;
    logic [11:0] ADDR = 12'h000;
    logic [31:0] WDATA = 32'h0000_0000;
    logic [31:0] RDATA, PORT_LOCK, REG_LEVEL;
    logic [4:0]  EXT_RESET_PIN;
    logic        CFG_READY, EXT_RESET_EN, EXT_RESET_PORT, PINS_ANTENNA;
    logic        PINS_GPIO, TRACE_EN, BKPT_EN, BKPT_WR_ALLOW;
    logic [10:0] dec_vec, last_dec;
    logic [11:0] ta;
    logic [31:0] shadow [logic [11:0]];
    integer seed = 69, fails = 0, num_checks = 0, r;
    logic [11:0] ra [6] = '{RST_SEL0_ADDR, RST_SEL1_ADDR, PORT_LOCK_ADDR,
        PIN_ROLE_ADDR, DEBUG_FEAT_ADDR, REG_LEVEL_ADDR};
    logic [11:0] ca [6] = '{PIN_ROLE_ADDR, DEBUG_FEAT_ADDR, DEBUG_FEAT_ADDR,
        RST_SEL0_ADDR, RST_SEL1_ADDR, PORT_LOCK_ADDR};
    logic [31:0] cd [6] = '{32'h0000_0000, 32'h0000_00ff, 32'hffff_ff00,
        32'h0000_0025, 32'h0000_0025, 32'h1234_5678};
    logic [11:0] ua [5] = '{12'h048, 12'h016, 12'h300, 12'h100, 12'h20e};
    assign dec_vec = {EXT_RESET_EN, EXT_RESET_PORT, EXT_RESET_PIN,
        PINS_ANTENNA, PINS_GPIO, TRACE_EN, BKPT_EN};
    ucfg_regs u_ucfg_regs (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .BKPT_WR(BKPT_WR), .RDATA(RDATA),
        .CFG_READY(CFG_READY), .EXT_RESET_EN(EXT_RESET_EN),
        .EXT_RESET_PIN(EXT_RESET_PIN), .EXT_RESET_PORT(EXT_RESET_PORT),
        .PINS_ANTENNA(PINS_ANTENNA), .PINS_GPIO(PINS_GPIO),
        .TRACE_EN(TRACE_EN), .BKPT_EN(BKPT_EN),
        .BKPT_WR_ALLOW(BKPT_WR_ALLOW), .PORT_LOCK(PORT_LOCK),
        .REG_LEVEL(REG_LEVEL));
    always #2.5 CLK = ~CLK;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic bit mapped(input logic [11:0] a);
        if (a[1:0] != 2'h0) return 1'b0;
        return (a >= FW_BASE && a < FW_BASE + 12'(4 * FW_COUNT))
            || (a >= HW_BASE && a < CUST_BASE + 12'(4 * CUST_COUNT))
            || a inside {ra};
    endfunction
    function automatic logic [31:0] exp_rd(input logic [11:0] a);
        if (!mapped(a)) return READ_ZERO;
        return shadow.exists(a) ? shadow[a] : ERASED_WORD;
    endfunction
    function automatic logic [10:0] exp_dec();
        logic [31:0] w0, w1, role, dbg;
        logic en;
        w0 = exp_rd(RST_SEL0_ADDR);
        w1 = exp_rd(RST_SEL1_ADDR);
        role = exp_rd(PIN_ROLE_ADDR);
        dbg = exp_rd(DEBUG_FEAT_ADDR);
        en = (w0 == w1) && w0[CONNECT_BIT] == CONNECTED;
        return {en, en ? w0[5:0] : 6'h00, role[ROLE_BIT], !role[ROLE_BIT],
            dbg[7:0] == FEATURE_ON, dbg[15:8] == FEATURE_ON};
    endfunction
    task automatic rd(input logic [11:0] a);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk(RDATA, exp_rd(a));
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input bit rb);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= rb;
        if (mapped(a)) shadow[a] = d;
        if (rb) begin
            @(posedge CLK);
            RD <= 1'b0;
            #1;
            chk(RDATA, exp_rd(a));
        end
    endtask
    task automatic rst_cfg(input logic [11:0] a, input logic [31:0] d,
                           input bit w);
        @(posedge CLK);
        ARST_N <= 1'b0;
        repeat (16) @(posedge CLK);
        ARST_N <= 1'b1;
        WR <= w;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
        if (w && mapped(a)) shadow[a] = d;
        last_dec = exp_dec();
        @(posedge CLK);
        #1;
        chk(32'(dec_vec), 32'(last_dec));
        chk(32'(CFG_READY), 32'h0000_0001);
        chk(PORT_LOCK, exp_rd(PORT_LOCK_ADDR));
        @(posedge CLK);
        BKPT_WR <= 1'b1;
        @(posedge CLK);
        BKPT_WR <= 1'b0;
        #1;
        chk(32'(BKPT_WR_ALLOW), 32'(last_dec[0]));
    endtask
    initial begin
        rst_cfg(12'h000, 32'h0000_0000, 1'b0);
        foreach (ra[i]) rd(ra[i]);
        rd(12'h044);
        rd(12'h0fc);
        for (int i = 0; i < 6; i++) rst_cfg(ca[i], cd[i], 1'b1);
        repeat (80) begin
            r = $unsigned($random(seed)) % 63;
            ta = r < 13 ? FW_BASE + 12'(4 * r) : r < 57 ?
                HW_BASE + 12'(4 * (r - 13)) : ra[r - 57];
            wr(ta, $random(seed), r[0]);
            if (!r[0]) rd(ta);
        end
        foreach (ua[i]) wr(ua[i], $random(seed), 1'b1);
        wr(REG_LEVEL_ADDR, 32'h0000_0a5c, 1'b0);
        @(posedge CLK);
        #1;
        chk(REG_LEVEL, 32'h0000_0a5c);
        wr(PIN_ROLE_ADDR, 32'h0000_0000, 1'b0);
        wr(DEBUG_FEAT_ADDR, 32'h0000_0000, 1'b0);
        repeat (2) @(posedge CLK);
        #1;
        chk(32'(dec_vec), 32'(last_dec));
        end_of_test();
    end
    initial begin
        #20us;
        fails++;
        end_of_test();
    end
endmodule
